// ==== src/mop_top.sv ====
// Motor overload content model, fault stop sequencer and auto-reset control.
// Assumes measurements and run state are synchronous to clk and an APB master.
`include "mop_defines.svh"
module mop_top
   import mop_pkg::*;
#(
   parameter int TICK_CYCLES = `MOP_TICK_NS / `MOP_CLK_NS
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire mop_run_state_t run_state,
   input wire mop_meas_t meas,
   input wire mop_fault_t fault_in,
   input wire logic stop_done,
   input wire logic up_to_speed_in,
   input wire logic [3:0] relay_in,
   output logic up_to_speed_indication,
   output logic [3:0] relay_out,
   output logic stop_request,
   output logic trip,
   output logic irq
);
   // ****************************************************************
   // Reset release and time base
   // ****************************************************************
   logic rst_meta_reg;
   logic rst_n;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   logic [19:0] div_reg;
   logic [7:0] sec_div_reg;
   logic base_tick;
   logic sec_tick;
   assign base_tick = (div_reg == 20'(TICK_CYCLES - 1));
   assign sec_tick = base_tick && (sec_div_reg == `MOP_TICKS_PER_SEC - 8'h01);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= 20'h00000;
         sec_div_reg <= 8'h00;
      end else begin
         div_reg <= base_tick ? 20'h00000 : div_reg + 20'h00001;
         if (sec_tick)
            sec_div_reg <= 8'h00;
         else if (base_tick)
            sec_div_reg <= sec_div_reg + 8'h01;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic ctrl_stop_en_reg;
   logic sep_ol_reg;
   logic [5:0] start_class_reg;
   logic [5:0] run_class_reg;
   logic [6:0] ratio_reg;
   logic [7:0] sf_reg;
   logic [13:0] cool_reg;
   logic [9:0] delay_reg;
   logic [3:0] limit_reg;
   logic [`MOP_IRQ_W-1:0] irq_stat_reg;
   logic [`MOP_IRQ_W-1:0] irq_mask_reg;
   logic [22:0] content_reg;
   logic [3:0] count_reg;
   logic lockout_reg;
   mop_fault_state_t fstate_reg;
   logic [`MOP_IRQ_W-1:0] events;

   logic wr;
   logic rd_setup;
   logic user_reset;
   assign wr = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign user_reset = wr && (paddr == `MOP_OFF_CTRL) && pwdata[2];

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `MOP_OFF_CTRL) || (a == `MOP_OFF_CLASS) || (a == `MOP_OFF_THERM) ||
         (a == `MOP_OFF_ARST) || (a == `MOP_OFF_STAT) || (a == `MOP_OFF_IRQS) ||
         (a == `MOP_OFF_IRQM);
   endfunction

   function automatic logic [5:0] clamp_class(input logic [5:0] v);
      clamp_class = (v > `MOP_MAX_CLASS) ? `MOP_MAX_CLASS : v;
   endfunction

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {sep_ol_reg, ctrl_stop_en_reg} <= `MOP_RST_CTRL;
         start_class_reg <= `MOP_RST_START_CLASS;
         run_class_reg <= `MOP_RST_RUN_CLASS;
         ratio_reg <= `MOP_RST_RATIO;
         sf_reg <= `MOP_RST_SF;
         cool_reg <= `MOP_RST_COOL;
         delay_reg <= 10'h000;
         limit_reg <= 4'h0;
         irq_mask_reg <= '0;
      end else if (wr) begin
         case (paddr)
            `MOP_OFF_CTRL: begin
               ctrl_stop_en_reg <= pwdata[0];
               sep_ol_reg <= pwdata[1];
            end
            `MOP_OFF_CLASS: begin
               start_class_reg <= clamp_class(pwdata[5:0]);
               run_class_reg <= clamp_class(pwdata[13:8]);
            end
            `MOP_OFF_THERM: begin
               ratio_reg <= (pwdata[6:0] > `MOP_MAX_RATIO) ? `MOP_MAX_RATIO : pwdata[6:0];
               sf_reg <= pwdata[15:8];
               if (pwdata[29:16] < `MOP_MIN_COOL)
                  cool_reg <= `MOP_MIN_COOL;
               else if (pwdata[29:16] > `MOP_MAX_COOL)
                  cool_reg <= `MOP_MAX_COOL;
               else
                  cool_reg <= pwdata[29:16];
            end
            `MOP_OFF_ARST: begin
               delay_reg <= (pwdata[9:0] > `MOP_MAX_DELAY) ? `MOP_MAX_DELAY : pwdata[9:0];
               limit_reg <= (pwdata[19:16] > `MOP_MAX_LIMIT) ? `MOP_MAX_LIMIT : pwdata[19:16];
            end
            `MOP_OFF_IRQM: irq_mask_reg <= pwdata[`MOP_IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // A new event in the cycle of its clearing write stays set.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         irq_stat_reg <= '0;
      else if (wr && paddr == `MOP_OFF_IRQS)
         irq_stat_reg <= (irq_stat_reg & ~pwdata[`MOP_IRQ_W-1:0]) | events;
      else
         irq_stat_reg <= irq_stat_reg | events;
   end
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // Read data is captured in the setup cycle so the access needs no wait state.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         case (paddr)
            `MOP_OFF_CTRL: prdata <= {30'h0, sep_ol_reg, ctrl_stop_en_reg};
            `MOP_OFF_CLASS: prdata <= {18'h0, run_class_reg, 2'h0, start_class_reg};
            `MOP_OFF_THERM: prdata <= {2'h0, cool_reg, sf_reg, 1'b0, ratio_reg};
            `MOP_OFF_ARST: prdata <= {12'h0, limit_reg, 6'h0, delay_reg};
            `MOP_OFF_STAT: prdata <= {9'h0, content_reg[22:`MOP_FRAC], 4'h0, count_reg,
               5'h00, stop_request, lockout_reg, trip};
            `MOP_OFF_IRQS: prdata <= {27'h0, irq_stat_reg};
            `MOP_OFF_IRQM: prdata <= {27'h0, irq_mask_reg};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   // ****************************************************************
   // Overload class selection and content model
   // ****************************************************************
   logic starting;
   logic [5:0] active_class;
   logic both_off;
   logic start_hold;
   logic calc_on;
   logic above_sf;
   logic [22:0] full_fx;
   logic [22:0] cap_fx;
   logic [22:0] target_fx;
   logic [31:0] ss_pct;
   logic [15:0] step_cnt_reg;
   logic model_tick;
   logic ol_full_reg;

   assign starting = (run_state == MOP_RS_KICK) || (run_state == MOP_RS_RAMP);
   assign active_class = (sep_ol_reg && starting) ? start_class_reg : run_class_reg;
   assign both_off = (start_class_reg == 6'h00) && (run_class_reg == 6'h00);
   assign start_hold = sep_ol_reg && starting && (start_class_reg == 6'h00) &&
      (run_class_reg != 6'h00);
   assign calc_on = (active_class != 6'h00) || start_hold;
   assign above_sf = meas.current_pct > {8'h00, sf_reg};
   assign full_fx = {`MOP_FULL_PCT, 16'h0000};
   assign cap_fx = {`MOP_CAP_PCT, 16'h0000};

   // Steady state follows current only up to full load; above it the target holds at 100%.
   always_comb begin
      ss_pct = 32'h00000000;
      if (meas.derate_pct != 8'h00)
         ss_pct = ({25'h0, ratio_reg} * {16'h0, meas.current_pct}) /
            {24'h0, meas.derate_pct};
      if (run_state == MOP_RS_STOPPED)
         target_fx = 23'h000000;
      else if (ss_pct > {25'h0, `MOP_FULL_PCT})
         target_fx = full_fx;
      else
         target_fx = {ss_pct[6:0], 16'h0000};
   end

   // A step every cool*3 ticks of 6.25 ms moves 1/64 of the gap; 320 steps
   // per cooling time give (63/64)^320, about e^-5.
   assign model_tick = base_tick &&
      (step_cnt_reg >= 16'(cool_reg) * 16'(`MOP_COOL_MULT) - 16'h0001);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         step_cnt_reg <= 16'h0000;
      else if (model_tick)
         step_cnt_reg <= 16'h0000;
      else if (base_tick)
         step_cnt_reg <= step_cnt_reg + 16'h0001;
   end

   logic [23:0] heated;
   logic signed [23:0] gap;
   logic [22:0] content_next;
   assign heated = {1'b0, content_reg} + {8'h00, meas.heat_step};
   assign gap = $signed({1'b0, target_fx}) - $signed({1'b0, content_reg});

   // Above service factor the external heating law adds its step each tick.
   always_comb begin
      content_next = content_reg;
      if (both_off)
         content_next = 23'h000000;
      else if (calc_on && !start_hold && above_sf && run_state != MOP_RS_STOPPED) begin
         if (base_tick)
            content_next = (heated > {1'b0, full_fx}) ? full_fx : heated[22:0];
      end else if (calc_on && model_tick)
         content_next = 23'(content_reg + 23'(gap >>> `MOP_STEP_SHIFT));
      if (start_hold && content_next > cap_fx)
         content_next = cap_fx;
      if (content_next > full_fx)
         content_next = full_fx;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         content_reg <= 23'h000000;
         ol_full_reg <= 1'b0;
      end else begin
         content_reg <= content_next;
         ol_full_reg <= (content_reg == full_fx) && (active_class != 6'h00);
      end
   end

   logic ol_trip;
   assign ol_trip = (content_reg == full_fx) && (active_class != 6'h00) && !ol_full_reg;

   // ****************************************************************
   // Fault stop sequencer and auto reset
   // ****************************************************************
   logic f_valid;
   logic f_crit;
   logic f_resettable;
   logic res_latched_reg;
   logic [9:0] ar_sec_reg;
   logic [9:0] clr_sec_reg;
   logic auto_fire;
   logic clr_done;
   logic lock_now;

   assign f_valid = fault_in.valid || ol_trip;
   assign f_crit = fault_in.valid && fault_in.critical;
   assign f_resettable = fault_in.valid ? fault_in.resettable : 1'b1;
   assign lock_now = (limit_reg != 4'h0) && (count_reg >= limit_reg);
   assign auto_fire = (fstate_reg == MOP_F_TRIP) && res_latched_reg && !lockout_reg &&
      !lock_now && (delay_reg != 10'h000) && sec_tick &&
      (ar_sec_reg + 10'h001 >= delay_reg);
   assign clr_done = (fstate_reg == MOP_F_IDLE) && !lockout_reg && (count_reg != 4'h0) &&
      sec_tick && (clr_sec_reg == `MOP_CLEAR_SEC - 10'h001);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fstate_reg <= MOP_F_IDLE;
         res_latched_reg <= 1'b0;
      end else begin
         case (fstate_reg)
            MOP_F_IDLE: begin
               if (f_valid) begin
                  res_latched_reg <= f_resettable;
                  if (!f_crit && ctrl_stop_en_reg && run_state != MOP_RS_STOPPED)
                     fstate_reg <= MOP_F_STOP;
                  else
                     fstate_reg <= MOP_F_TRIP;
               end
            end
            MOP_F_STOP: begin
               if (f_crit) begin
                  fstate_reg <= MOP_F_TRIP;
                  res_latched_reg <= res_latched_reg && fault_in.resettable;
               end else if (stop_done) begin
                  fstate_reg <= MOP_F_TRIP;
               end
            end
            MOP_F_TRIP: begin
               if (user_reset || auto_fire)
                  fstate_reg <= MOP_F_IDLE;
            end
            default: fstate_reg <= MOP_F_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         ar_sec_reg <= 10'h000;
      else if (fstate_reg != MOP_F_TRIP || auto_fire)
         ar_sec_reg <= 10'h000;
      else if (sec_tick)
         ar_sec_reg <= ar_sec_reg + 10'h001;
   end

   // The clearing timer runs on the one-second tick and restarts on any fault.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         clr_sec_reg <= 10'h000;
      else if (f_valid || fstate_reg != MOP_F_IDLE || clr_done)
         clr_sec_reg <= 10'h000;
      else if (sec_tick && count_reg != 4'h0)
         clr_sec_reg <= clr_sec_reg + 10'h001;
   end

   // Reset gives a zero count, so power cycling always clears it.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 4'h0;
         lockout_reg <= 1'b0;
      end else if (user_reset) begin
         count_reg <= 4'h0;
         lockout_reg <= 1'b0;
      end else begin
         if (auto_fire)
            count_reg <= count_reg + 4'h1;
         else if (clr_done)
            count_reg <= 4'h0;
         if (fstate_reg == MOP_F_TRIP && res_latched_reg && lock_now)
            lockout_reg <= 1'b1;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         relay_out <= 4'h0;
         up_to_speed_indication <= 1'b0;
      end else begin
         up_to_speed_indication <= up_to_speed_in;
         if (fstate_reg != MOP_F_STOP)
            relay_out <= relay_in;
      end
   end
   assign stop_request = (fstate_reg == MOP_F_STOP);
   assign trip = (fstate_reg == MOP_F_TRIP);
   // The lockout event uses the lockout flop's set condition, so a fault that cannot lock never raises it.
   assign events = {clr_done, stop_request && !stop_done,
      lock_now && trip && res_latched_reg && !lockout_reg,
      auto_fire, f_valid && fstate_reg == MOP_F_IDLE};

   // ****************************************************************
   // Assertions
   // ****************************************************************
   relay_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (fstate_reg == MOP_F_STOP) ##1 (fstate_reg == MOP_F_STOP) |-> $stable(relay_out))
      else $error("Relays moved during a controlled stop.");
   critical_trip_a: assert property (@(posedge clk) disable iff (!rst_n)
      (fstate_reg != MOP_F_TRIP && f_crit) |=> trip)
      else $error("Critical fault did not trip at once.");
   ctrl_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
      (fstate_reg == MOP_F_IDLE && f_valid && !f_crit && ctrl_stop_en_reg &&
      run_state != MOP_RS_STOPPED) |=> stop_request && !trip)
      else $error("Eligible fault skipped the controlled stop.");
   both_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      both_off |=> content_reg == 23'h000000)
      else $error("Content kept with both classes off.");
   start_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
      start_hold |=> content_reg <= cap_fx)
      else $error("Content above cap while starting with class off.");
   lock_count_a: assert property (@(posedge clk) disable iff (!rst_n)
      lockout_reg && !user_reset |=> $stable(count_reg) && lockout_reg)
      else $error("Locked count changed without a user reset.");
   count_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      clr_done |=> count_reg == 4'h0 ##1 count_reg == 4'h0)
      else $error("Count not cleared after quiet time.");
   class_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
      !sep_ol_reg |-> active_class == run_class_reg)
      else $error("Starting class used with separate overload off.");
   content_max_a: assert property (@(posedge clk) disable iff (!rst_n)
      content_reg <= full_fx)
      else $error("Content above full scale.");
endmodule // mop_top

// ==== src/mop_defines.svh ====
// Constants of the motor overload and fault protection block.
// Assumes a 125 MHz clock and an APB master with 32-bit data.
// Behaviour
// - At lockout the auto-reset count clears only on a user reset.
// - Below the limit the count clears after 15 minutes with no fault.
// - The auto-reset count is zero after power-up.
// - Controlled-stop enable, default On, runs the stop action before tripping.
// - During a controlled stop all relays but up-to-speed hold state.
// - Critical faults trip at once; only eligible faults stop under control.
// - Separate start/run overload Off: running class in every state.
// - Separate On: starting class in kick and ramp, running class otherwise.
// - Both classes Off: content erased, no overload calculation.
// - Starting class Off: no accumulation starting, content kept, capped at 99%; the code still steps content toward steady state.
// - Starting class is Off or 1 to 40, default 10.
// - Overload content runs 0 to 100%, 100% meaning tripped.
// - Steady state is ratio times current over full load, over derate.
// - Content moves toward steady state at a rate set by cooling time.
// - Stopped, content decays by e to minus 5t over cooling time.
// - Cooling time is 1.0 to 999.9 minutes in tenths, default 30.0.
// - Auto-reset limit Off or 1 to 10 caps automatic resets.
// - Auto-reset delay Off or 1 to 900 seconds, then a new start needed.
`ifndef MOP_DEFINES_SVH
`define MOP_DEFINES_SVH
`define MOP_OFF_CTRL 8'h00
`define MOP_OFF_CLASS 8'h04
`define MOP_OFF_THERM 8'h08
`define MOP_OFF_ARST 8'h0C
`define MOP_OFF_STAT 8'h10
`define MOP_OFF_IRQS 8'h14
`define MOP_OFF_IRQM 8'h18
`define MOP_RST_CTRL 2'h1
`define MOP_RST_START_CLASS 6'h0A
`define MOP_RST_RUN_CLASS 6'h0A
`define MOP_RST_RATIO 7'h3C
`define MOP_RST_SF 8'h73
`define MOP_RST_COOL 14'h012C
`define MOP_MAX_CLASS 6'h28
`define MOP_MAX_RATIO 7'h63
`define MOP_MIN_COOL 14'h000A
`define MOP_MAX_COOL 14'h270F
`define MOP_MAX_LIMIT 4'hA
`define MOP_MAX_DELAY 10'h384
`define MOP_FULL_PCT 7'h64
`define MOP_CAP_PCT 7'h63
`define MOP_FRAC 16
`define MOP_STEP_SHIFT 6
`define MOP_COOL_MULT 3
`define MOP_TICK_NS 6250000
`define MOP_CLK_NS 8
`define MOP_TICKS_PER_SEC 8'hA0
`define MOP_CLEAR_SEC 10'h384
`define MOP_IRQ_W 5
`endif

// ==== src/mop_pkg.sv ====
// Types shared by the protection block and its surroundings.
// Assumes the constants header is included by users of numbers.
package mop_pkg;
   typedef enum logic [2:0] {
      MOP_RS_STOPPED, MOP_RS_KICK, MOP_RS_RAMP, MOP_RS_RUN, MOP_RS_DECEL
   } mop_run_state_t;
   typedef enum {MOP_F_IDLE, MOP_F_STOP, MOP_F_TRIP} mop_fault_state_t;
   typedef struct packed {
      logic valid;
      logic critical;
      logic resettable;
   } mop_fault_t;
   typedef struct packed {
      logic [15:0] current_pct;
      logic [7:0] derate_pct;
      logic [15:0] heat_step;
   } mop_meas_t;
endpackage

// ==== test/mop_motor_model.sv ====
// Behavioural far side of the protection block: run-state sequencer and sensed currents.
// Assumes stop_request is a level that stays high until stop_done has been seen.
module mop_motor_model
   import mop_pkg::*;
#(
   parameter int STOP_CYCLES = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire mop_run_state_t run_cmd,
   input wire logic stop_request,
   output mop_run_state_t run_state,
   output mop_meas_t meas,
   output logic stop_done
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   // Half of full load with no imbalance keeps the heating law out of play.
   assign meas = '{current_pct: 16'h0032, derate_pct: 8'h64, heat_step: 16'h0000};
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 0;
         stop_done <= 1'b0;
         run_state <= MOP_RS_STOPPED;
      end else if (stop_request) begin
         run_state <= MOP_RS_DECEL;
         cnt <= cnt + 1;
         stop_done <= (cnt == STOP_CYCLES);
      end else begin
         cnt <= 0;
         stop_done <= 1'b0;
         run_state <= run_cmd;
      end
   end
endmodule // mop_motor_model

// ==== test/motor_overload_fault_protection_tb_top.sv ====
// Self-checking bench of the protection block with its far-side model.
// Assumes a short tick so that one second lasts 640 clock cycles.
`include "mop_defines.svh"
module motor_overload_fault_protection_tb_top
   import mop_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, stop_done, up_to_speed_in;
   logic up_to_speed_indication, stop_request, trip, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] relay_in, relay_out;
   mop_run_state_t run_state, run_cmd;
   mop_meas_t meas;
   mop_fault_t fault_in;
   int errors, tests_run;
   mop_top #(.TICK_CYCLES(4)) mop_top_i (.clk(clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .run_state(run_state), .meas(meas),
      .fault_in(fault_in), .stop_done(stop_done), .up_to_speed_in(up_to_speed_in),
      .relay_in(relay_in), .up_to_speed_indication(up_to_speed_indication),
      .relay_out(relay_out), .stop_request(stop_request), .trip(trip), .irq(irq));
   mop_motor_model mop_motor_model_i (.clk(clk), .rstn(rstn), .run_cmd(run_cmd),
      .stop_request(stop_request), .run_state(run_state), .meas(meas),
      .stop_done(stop_done));
   always #4 clk = ~clk;
   // ************************************************************
   // Bus and check tasks
   // ************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      // Unmapped places answer with an error; mapped ones never do.
      chk(32'(pslverr), 32'(a > `MOP_OFF_IRQM), "slave error");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      apb(1'b1, a, d, rd);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
      logic [31:0] rd;
      apb(1'b0, a, 32'h0, rd);
      chk(rd & msk, exp, "register read");
   endtask
   task automatic pulse(input mop_fault_t f);
      @(posedge clk);
      fault_in <= f;
      @(posedge clk);
      fault_in <= '0;
      #1;
   endtask
   task automatic wait_trip(input logic v, input int lim);
      int n;
      n = 0;
      while (trip !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
      #1;
      chk(32'(trip), 32'(v), "trip level");
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      errors++;
      stop_test;
   end
   // ************************************************************
   // Test sequence
   // ************************************************************
   initial begin
      clk = 0;
      rstn = 0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      fault_in = '0;
      up_to_speed_in = 0;
      relay_in = 4'h0;
      run_cmd = MOP_RS_STOPPED;
      errors = 0;
      tests_run = 0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk(`MOP_OFF_CTRL, 32'h00000001, 32'hFFFFFFFF);
      rd_chk(`MOP_OFF_CLASS, 32'h00000A0A, 32'hFFFFFFFF);
      rd_chk(`MOP_OFF_THERM, 32'h012C733C, 32'hFFFFFFFF);
      rd_chk(`MOP_OFF_STAT, 32'h00000000, 32'hFFFFFFFF);
      rd_chk(8'h1C, 32'h00000000, 32'hFFFFFFFF);
      $display("test reset_values done");
      wr(`MOP_OFF_CLASS, 32'hFFFFFFFF);
      rd_chk(`MOP_OFF_CLASS, 32'h00002828, 32'hFFFFFFFF);
      wr(`MOP_OFF_THERM, 32'h00000000);
      rd_chk(`MOP_OFF_THERM, 32'h000A0000, 32'hFFFFFFFF);
      wr(`MOP_OFF_THERM, 32'hFFFFFFFF);
      rd_chk(`MOP_OFF_THERM, 32'h270FFF63, 32'hFFFFFFFF);
      wr(`MOP_OFF_ARST, 32'hFFFFFFFF);
      rd_chk(`MOP_OFF_ARST, 32'h000A0384, 32'hFFFFFFFF);
      wr(`MOP_OFF_CLASS, 32'h00000A0A);
      wr(`MOP_OFF_THERM, 32'h012C733C);
      wr(`MOP_OFF_ARST, 32'h00000000);
      $display("test setting_ranges done");
      run_cmd <= MOP_RS_RUN;
      relay_in <= 4'h3;
      up_to_speed_in <= 1'b1;
      repeat (3) @(posedge clk);
      pulse('{valid: 1'b1, critical: 1'b0, resettable: 1'b1});
      chk(32'(stop_request), 32'h1, "stop request");
      chk(32'(trip), 32'h0, "trip before stop");
      @(posedge clk);
      relay_in <= 4'hC;
      up_to_speed_in <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(32'(relay_out), 32'h3, "relays held");
      chk(32'(up_to_speed_indication), 32'h0, "up to speed");
      wait_trip(1'b1, 100);
      chk(32'(stop_request), 32'h0, "stop request end");
      rd_chk(`MOP_OFF_STAT, 32'h00000001, 32'h00000007);
      wr(`MOP_OFF_CTRL, 32'h00000005);
      wait_trip(1'b0, 4);
      $display("test controlled_stop done");
      wr(`MOP_OFF_IRQS, 32'h0000001F);
      wr(`MOP_OFF_IRQM, 32'h00000001);
      pulse('{valid: 1'b1, critical: 1'b1, resettable: 1'b0});
      chk(32'(trip), 32'h1, "critical trip");
      chk(32'(stop_request), 32'h0, "no controlled stop");
      chk(32'(irq), 32'h1, "interrupt raised");
      wr(`MOP_OFF_IRQS, 32'h0000001F);
      #1;
      chk(32'(irq), 32'h0, "interrupt cleared");
      wr(`MOP_OFF_CTRL, 32'h00000005);
      wait_trip(1'b0, 4);
      $display("test critical_fault done");
      wr(`MOP_OFF_CTRL, 32'h00000000);
      wr(`MOP_OFF_ARST, 32'h00010001);
      run_cmd <= MOP_RS_STOPPED;
      pulse('{valid: 1'b1, critical: 1'b0, resettable: 1'b1});
      chk(32'(trip), 32'h1, "direct trip");
      wait_trip(1'b0, 1500);
      rd_chk(`MOP_OFF_STAT, 32'h00000100, 32'h00000F03);
      pulse('{valid: 1'b1, critical: 1'b0, resettable: 1'b1});
      repeat (1500) @(posedge clk);
      #1;
      chk(32'(trip), 32'h1, "locked out");
      rd_chk(`MOP_OFF_STAT, 32'h00000103, 32'h00000F03);
      wr(`MOP_OFF_CTRL, 32'h00000004);
      rd_chk(`MOP_OFF_STAT, 32'h00000000, 32'h00000F03);
      $display("test auto_reset done");
      // A one-minute cooling time steps the content every 120 cycles, 1/64 of the gap
      // to 30%; the three or four steps seen in the 400 cycles of kick leave it at 1%.
      wr(`MOP_OFF_THERM, 32'h000A733C);
      wr(`MOP_OFF_CTRL, 32'h00000002);
      wr(`MOP_OFF_CLASS, 32'h0000000A);
      run_cmd <= MOP_RS_RUN;
      repeat (400) @(posedge clk);
      rd_chk(`MOP_OFF_STAT, 32'h00000000, 32'h007F0000);
      run_cmd <= MOP_RS_KICK;
      wr(`MOP_OFF_CLASS, 32'h00000A00);
      repeat (400) @(posedge clk);
      rd_chk(`MOP_OFF_STAT, 32'h00010000, 32'h007F0000);
      wr(`MOP_OFF_CLASS, 32'h00000A0A);
      run_cmd <= MOP_RS_STOPPED;
      repeat (6000) @(posedge clk);
      rd_chk(`MOP_OFF_STAT, 32'h00000000, 32'h007F0000);
      $display("test content_model done");
      stop_test;
   end
endmodule // motor_overload_fault_protection_tb_top
